/* rtl/stepper_pkg.sv */
// Purpose: Shared constants, types and translator functions for the stepper output control.
// Assumes: 32-bit APB, one aligned word per register, 125 MHz pclk.
// Notes: Each line below states one rule that the logic carries.
// Behaviour
// - Output enable low drives bridges; high turns every bridge transistor off.
// - Advance, direction and microstep selects work regardless of output enable.
// - Overtemperature or gate supply undervoltage disables outputs until it clears.
// - Supply lockout disables drivers and returns the translator to Home.
// - Sleep low turns off outputs, current regulator and charge pump.
// - Leaving sleep resumes operation and moves the translator to Home.
// - A step lowering winding current uses the decay mode from the fraction level.
// - Fraction level above 0.6 of logic supply selects slow decay.
// - Fraction level below 0.21 of logic supply selects fast decay.
// - Fraction level between thresholds selects mixed decay per the step sequence.
// - Mixed decay: at trip go fast until off-timer node reaches fraction level.
// - After the fast part, slow decay runs for the rest of the off-time.
// - During off-time the transistors of the chosen decay mode are switched on.
// - Rectifier disable low allows synchronous rectification during decay.
// - In active rectification, zero winding current turns rectification off.
// - Rectifier disable high never applies synchronous rectification.
// - Drivers off at about 165 C, back on after falling about 15 C.
// - Equal or higher next current level always uses slow decay.
// - Each advance rising edge moves translator one increment, updating both windings.
// - Reset low holds Home, disables outputs and ignores advance edges.
package stepper_pkg;
    // Register byte offsets.
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] LEVEL_OFS = 8'h08;
    // Control field positions and reset value.
    localparam int CTRL_OEN_N_BIT = 0;
    localparam int CTRL_SLEEP_N_BIT = 1;
    localparam int CTRL_RESET_N_BIT = 2;
    localparam int CTRL_RECT_DIS_BIT = 3;
    localparam int CTRL_DIR_BIT = 4;
    localparam int CTRL_MS_LO_BIT = 5;
    localparam int CTRL_MS_HI_BIT = 6;
    localparam int CTRL_ADVANCE_BIT = 7;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0017;
    localparam logic [31:0] CTRL_WMASK = 32'h0000_00FF;
    // Status field positions.
    localparam int ST_HOME_BIT = 0;
    localparam int ST_OUT_ON_BIT = 1;
    localparam int ST_HOT_BIT = 2;
    localparam int ST_GATE_LOW_BIT = 3;
    localparam int ST_LOCKOUT_BIT = 4;
    localparam int ST_WAKE_BIT = 5;
    localparam int ST_MODE1_POS = 8;
    localparam int ST_MODE2_POS = 10;
    localparam int ST_POS_POS = 16;
    localparam int LVL_NEG_BIT = 10;
    localparam int LVL_PH2_POS = 16;
    // Translator geometry: 64 sixteenth positions per electrical turn.
    localparam logic [5:0] HOME_POS = 6'h08;
    localparam logic [5:0] QUARTER_TURN = 6'h10;
    // Thermal shutdown in degrees C.
    localparam logic [7:0] TEMP_TRIP_C = 8'hA5;
    localparam logic [7:0] TEMP_HYST_C = 8'h0F;
    // Gate drive settling after wake.
    localparam int WAKE_TIME_US = 1000;
    localparam int CLK_FREQ_MHZ = 125;
    localparam int WAKE_CYCLES = WAKE_TIME_US * CLK_FREQ_MHZ;

    typedef enum logic [1:0] {DECAY_SLOW = 2'b00, DECAY_MIXED = 2'b01, DECAY_FAST = 2'b10} decay_t;
    typedef enum logic [3:0] {S_OFF = 4'b0001, S_DRIVE = 4'b0010, S_FAST = 4'b0100,
                              S_SLOW = 4'b1000} bridge_state_t;

    // Current magnitude in tenths of a percent of full trip, one entry per 5.625 degrees.
    function automatic logic [9:0] mag_table(input logic [4:0] k);
        case (k)
            5'h00: mag_table = 10'h3E8;
            5'h01: mag_table = 10'h3E3;
            5'h02: mag_table = 10'h3D5;
            5'h03: mag_table = 10'h3BD;
            5'h04: mag_table = 10'h39C;
            5'h05: mag_table = 10'h372;
            5'h06: mag_table = 10'h340;
            5'h07: mag_table = 10'h305;
            5'h08: mag_table = 10'h2C3;
            5'h09: mag_table = 10'h27A;
            5'h0A: mag_table = 10'h22C;
            5'h0B: mag_table = 10'h1D7;
            5'h0C: mag_table = 10'h17F;
            5'h0D: mag_table = 10'h122;
            5'h0E: mag_table = 10'h0C3;
            5'h0F: mag_table = 10'h062;
            default: mag_table = 10'h000;
        endcase
    endfunction

    // Cosine magnitude of a translator angle.
    function automatic logic [9:0] level_of(input logic [5:0] ang);
        level_of = mag_table(ang[4] ? 5'(5'h10 - {1'b0, ang[3:0]}) : {1'b0, ang[3:0]});
    endfunction

    // Cosine sign of a translator angle, high when negative.
    function automatic logic negative_of(input logic [5:0] ang);
        negative_of = (ang[5:4] == 2'b01 && ang[3:0] != 4'h0) || ang[5:4] == 2'b10;
    endfunction
endpackage

/* rtl/thermal_guard.sv */
// Purpose: Thermal shutdown flag with hysteresis.
// Assumes: junction temperature arrives as an unsigned code in degrees C.
// Notes: Flag sets at the trip level and clears only at or below trip minus hysteresis.
`timescale 1ns/1ps
module thermal_guard
    import stepper_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] temp_c,
    output logic hot_q
);
    // Set at trip, hold through the hysteresis band, release once cooled.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            hot_q <= 1'b0;
        else if (temp_c >= TEMP_TRIP_C)
            hot_q <= 1'b1;
        else if (temp_c <= 8'(TEMP_TRIP_C - TEMP_HYST_C))
            hot_q <= 1'b0;
    end

    a_thermal_band: assert property (@(posedge pclk) disable iff (!presetn)
        hot_q && temp_c > 8'(TEMP_TRIP_C - TEMP_HYST_C) |=> hot_q)
        else $error("thermal flag released inside hysteresis band");
endmodule // thermal_guard

/* rtl/bridge_decay_sequencer.sv */
// Purpose: Gate sequencing of one full bridge through drive and decay phases.
// Assumes: trip, off-timer and zero-current indications are synchronous comparator levels.
// Notes: gate bits are source A, sink A, source B, sink B from bit 0 upward.
`timescale 1ns/1ps
module bridge_decay_sequencer
    import stepper_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic enable,
    input wire logic drive_neg,
    input decay_t mode,
    input wire logic rect_disable,
    input wire logic trip,
    input wire logic fraction_reached,
    input wire logic off_expired,
    input wire logic zero_current,
    output logic [3:0] gate_q
);
    bridge_state_t state_q, state_d;
    logic [3:0] drive;
    logic rect_ok;

    // Phase stepping: drive until trip, then decay for the fixed off-time.
    always_comb
    begin
        state_d = state_q;
        if (!enable)
            state_d = S_OFF;
        else
            case (state_q)
                S_OFF: state_d = S_DRIVE;
                S_DRIVE: if (trip) state_d = (mode == DECAY_SLOW) ? S_SLOW : S_FAST;
                S_FAST: if (off_expired) state_d = S_DRIVE;
                        else if (mode == DECAY_MIXED && fraction_reached) state_d = S_SLOW;
                S_SLOW: if (off_expired) state_d = S_DRIVE;
                default: state_d = S_OFF;
            endcase
    end

    assign drive = drive_neg ? 4'b0110 : 4'b1001;
    assign rect_ok = !rect_disable && !zero_current;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_q <= S_OFF;
        else
            state_q <= state_d;
    end

    // Fast decay turns on the opposite diagonal, slow decay both sinks, when rectifying.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            gate_q <= 4'h0;
        else
            case (state_d)
                S_DRIVE: gate_q <= drive;
                S_FAST: gate_q <= rect_ok ? ~drive : 4'h0;
                S_SLOW: gate_q <= rect_ok ? 4'b1010 : (drive & 4'b1010);
                default: gate_q <= 4'h0;
            endcase
    end

    sequence s_mixed_trip;
        enable && state_q == S_DRIVE && trip && mode == DECAY_MIXED;
    endsequence
    a_mixed_fast_slow: assert property (@(posedge pclk) disable iff (!presetn)
        s_mixed_trip ##1 (enable && mode == DECAY_MIXED && fraction_reached && !off_expired)
        |=> state_q == S_SLOW)
        else $error("mixed decay did not pass from fast to slow");
    a_no_rectify: assert property (@(posedge pclk) disable iff (!presetn)
        $past(rect_disable) && state_q == S_FAST |-> gate_q == 4'h0)
        else $error("rectification applied while disabled");
endmodule // bridge_decay_sequencer

/* rtl/stepper_output_decay_control.sv */
// Purpose: Translator, decay selection and output gating of a two-bridge stepper driver.
// Assumes: APB slave with zero wait states; analog comparators arrive as synchronous levels.
// Notes: Read data is captured in the setup phase, so reads return the setup-cycle value.
`timescale 1ns/1ps
module stepper_output_decay_control
    import stepper_pkg::*;
#(
    parameter int WAKE_CYCLES_P = WAKE_CYCLES
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] decay_fraction_level,
    input wire logic supply_lockout,
    input wire logic gate_supply_rail_low,
    input wire logic [7:0] junction_temp_c,
    input wire logic [1:0] current_trip,
    input wire logic [1:0] off_timer_node_at_fraction,
    input wire logic [1:0] off_timer_expired,
    input wire logic [1:0] zero_current,
    output logic [3:0] bridge1_gate,
    output logic [3:0] bridge2_gate,
    output logic [9:0] phase1_level,
    output logic phase1_neg,
    output logic [9:0] phase2_level,
    output logic phase2_neg,
    output logic home,
    output logic charge_pump_on,
    output logic regulator_on
);
    logic [31:0] ctrl_q;
    logic [31:0] prdata_q;
    logic adv_prev_q;
    logic sleep_prev_q;
    logic [5:0] pos_q;
    logic [5:0] inc;
    logic [5:0] pos_next;
    decay_t mode1_q;
    decay_t mode2_q;
    decay_t fraction_code;
    logic [9:0] lvl1_q;
    logic [9:0] lvl2_q;
    logic neg1_q;
    logic neg2_q;
    logic [31:0] wake_cnt_q;
    logic wake_ready_q;
    logic hot;
    logic out_enable_n;
    logic sleep_n;
    logic run_n;
    logic rect_disable;
    logic direction;
    logic microstep_select_lo;
    logic microstep_select_hi;
    logic fault;
    logic outputs_on;
    logic wake_edge;
    logic go_home;
    logic step_edge;
    logic wr_en;
    logic rd_setup;
    logic mapped;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Control fields as seen by the datapath.
    assign out_enable_n = ctrl_q[CTRL_OEN_N_BIT];
    assign sleep_n = ctrl_q[CTRL_SLEEP_N_BIT];
    assign run_n = ctrl_q[CTRL_RESET_N_BIT];
    assign rect_disable = ctrl_q[CTRL_RECT_DIS_BIT];
    assign direction = ctrl_q[CTRL_DIR_BIT];
    assign microstep_select_lo = ctrl_q[CTRL_MS_LO_BIT];
    assign microstep_select_hi = ctrl_q[CTRL_MS_HI_BIT];

    // APB decode: three words, anything else errors and reads zero.
    assign mapped = paddr == CTRL_OFS || paddr == STATUS_OFS || paddr == LEVEL_OFS;
    assign wr_en = psel && penable && pwrite && paddr == CTRL_OFS;
    assign rd_setup = psel && !penable;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = prdata_q;

    // Control register; only the low byte holds state.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_q <= CTRL_RESET;
        else if (wr_en)
            ctrl_q <= pwdata & CTRL_WMASK;
    end

    // Read data is sampled in the setup cycle so it comes from a flip-flop.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_q <= 32'h0000_0000;
        else if (rd_setup)
        begin
            if (paddr == CTRL_OFS)
                prdata_q <= ctrl_q;
            else if (paddr == STATUS_OFS)
            begin
                prdata_q <= 32'h0000_0000;
                prdata_q[ST_HOME_BIT] <= home;
                prdata_q[ST_OUT_ON_BIT] <= outputs_on;
                prdata_q[ST_HOT_BIT] <= hot;
                prdata_q[ST_GATE_LOW_BIT] <= gate_supply_rail_low;
                prdata_q[ST_LOCKOUT_BIT] <= supply_lockout;
                prdata_q[ST_WAKE_BIT] <= wake_ready_q;
                prdata_q[ST_MODE1_POS +: 2] <= mode1_q;
                prdata_q[ST_MODE2_POS +: 2] <= mode2_q;
                prdata_q[ST_POS_POS +: 6] <= pos_q;
            end
            else if (paddr == LEVEL_OFS)
            begin
                prdata_q <= 32'h0000_0000;
                prdata_q[9:0] <= lvl1_q;
                prdata_q[LVL_NEG_BIT] <= neg1_q;
                prdata_q[LVL_PH2_POS +: 10] <= lvl2_q;
                prdata_q[LVL_PH2_POS + LVL_NEG_BIT] <= neg2_q;
            end
            else
                prdata_q <= 32'h0000_0000;
        end
    end

    // Edge history of the advance bit and of the sleep release.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            adv_prev_q <= 1'b0;
            sleep_prev_q <= CTRL_RESET[CTRL_SLEEP_N_BIT];
        end
        else
        begin
            adv_prev_q <= ctrl_q[CTRL_ADVANCE_BIT];
            sleep_prev_q <= sleep_n;
        end
    end

    // Home is forced by lockout, by the reset bit, and on leaving sleep.
    assign wake_edge = sleep_n && !sleep_prev_q;
    assign go_home = supply_lockout || !run_n || wake_edge;
    // Advance works whatever the output enable says.
    assign step_edge = ctrl_q[CTRL_ADVANCE_BIT] && !adv_prev_q && !go_home;

    // Increment size from the microstep selects; direction picks the sign.
    always_comb
    begin
        case ({microstep_select_hi, microstep_select_lo})
            2'b00: inc = 6'h10;
            2'b01: inc = 6'h08;
            2'b10: inc = 6'h04;
            default: inc = 6'h01;
        endcase
        pos_next = direction ? 6'(pos_q + inc) : 6'(pos_q - inc);
    end

    // Comparator code; the unused code is read as mixed.
    assign fraction_code = (decay_fraction_level == DECAY_FAST) ? DECAY_FAST :
                           (decay_fraction_level == DECAY_SLOW) ? DECAY_SLOW : DECAY_MIXED;

    // Translator position.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pos_q <= HOME_POS;
        else if (go_home)
            pos_q <= HOME_POS;
        else if (step_edge)
            pos_q <= pos_next;
    end

    // Decay choice per bridge, taken at each step from the level trend.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode1_q <= DECAY_MIXED;
            mode2_q <= DECAY_MIXED;
        end
        else if (go_home)
        begin
            mode1_q <= DECAY_MIXED;
            mode2_q <= DECAY_MIXED;
        end
        else if (step_edge)
        begin
            if (level_of(pos_next) < level_of(pos_q))
                mode1_q <= fraction_code;
            else
                mode1_q <= DECAY_SLOW;
            if (level_of(6'(pos_next - QUARTER_TURN)) < level_of(6'(pos_q - QUARTER_TURN)))
                mode2_q <= fraction_code;
            else
                mode2_q <= DECAY_SLOW;
        end
    end

    // Winding levels and polarities follow the position one cycle later.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lvl1_q <= 10'h000;
            lvl2_q <= 10'h000;
            neg1_q <= 1'b0;
            neg2_q <= 1'b0;
        end
        else
        begin
            lvl1_q <= level_of(pos_q);
            lvl2_q <= level_of(6'(pos_q - QUARTER_TURN));
            neg1_q <= negative_of(pos_q);
            neg2_q <= negative_of(6'(pos_q - QUARTER_TURN));
        end
    end

    assign phase1_level = lvl1_q;
    assign phase2_level = lvl2_q;
    assign phase1_neg = neg1_q;
    assign phase2_neg = neg2_q;
    assign home = pos_q == HOME_POS;

    // Gate drive settle indication after leaving sleep.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wake_cnt_q <= 32'h0000_0000;
            wake_ready_q <= 1'b0;
        end
        else if (!sleep_n)
        begin
            wake_cnt_q <= 32'h0000_0000;
            wake_ready_q <= 1'b0;
        end
        else if (wake_cnt_q < 32'(WAKE_CYCLES_P))
            wake_cnt_q <= wake_cnt_q + 32'h0000_0001;
        else
            wake_ready_q <= 1'b1;
    end

    thermal_guard u_thermal (
        .pclk(pclk),
        .presetn(presetn),
        .temp_c(junction_temp_c),
        .hot_q(hot)
    );

    // Faults, lockout, sleep, reset and the enable pin all gate the bridges.
    assign fault = hot || gate_supply_rail_low;
    assign outputs_on = !out_enable_n && sleep_n && run_n && !fault && !supply_lockout;
    assign charge_pump_on = sleep_n;
    assign regulator_on = sleep_n;

    bridge_decay_sequencer u_bridge1 (
        .pclk(pclk),
        .presetn(presetn),
        .enable(outputs_on),
        .drive_neg(neg1_q),
        .mode(mode1_q),
        .rect_disable(rect_disable),
        .trip(current_trip[0]),
        .fraction_reached(off_timer_node_at_fraction[0]),
        .off_expired(off_timer_expired[0]),
        .zero_current(zero_current[0]),
        .gate_q(bridge1_gate)
    );

    bridge_decay_sequencer u_bridge2 (
        .pclk(pclk),
        .presetn(presetn),
        .enable(outputs_on),
        .drive_neg(neg2_q),
        .mode(mode2_q),
        .rect_disable(rect_disable),
        .trip(current_trip[1]),
        .fraction_reached(off_timer_node_at_fraction[1]),
        .off_expired(off_timer_expired[1]),
        .zero_current(zero_current[1]),
        .gate_q(bridge2_gate)
    );

    // Checks of output gating, translator stepping and decay choice.
    a_enable_gates: assert property (
        out_enable_n |=> bridge1_gate == 4'h0 && bridge2_gate == 4'h0)
        else $error("bridge driven while output enable is high");

    a_step_ignores_enable: assert property (
        out_enable_n && step_edge |=> pos_q != $past(pos_q))
        else $error("advance lost while outputs disabled");

    a_fault_off: assert property (
        fault [*2] |-> bridge1_gate == 4'h0 && bridge2_gate == 4'h0)
        else $error("bridge driven during fault");

    a_lockout_home: assert property (
        supply_lockout |=> home && bridge1_gate == 4'h0 && bridge2_gate == 4'h0)
        else $error("lockout did not disable and home");

    a_sleep_off: assert property (
        !sleep_n |-> !charge_pump_on && !regulator_on ##1 bridge1_gate == 4'h0)
        else $error("sleep left circuitry running");

    a_wake_home: assert property (
        wake_edge |=> home && mode1_q == DECAY_MIXED)
        else $error("wake did not return to home");

    a_falling_decay: assert property (
        step_edge && level_of(pos_next) < level_of(pos_q) |=> mode1_q == $past(fraction_code))
        else $error("falling step ignored fraction level");

    a_rising_slow: assert property (
        step_edge && level_of(pos_next) >= level_of(pos_q) |=> mode1_q == DECAY_SLOW)
        else $error("rising step did not use slow decay");

    a_reset_hold: assert property (
        !run_n [*2] |-> home && bridge2_gate == 4'h0)
        else $error("reset did not hold home with outputs off");

    a_level_track: assert property (
        step_edge |=> ##1 lvl1_q == level_of($past(pos_next, 2)))
        else $error("winding level did not follow step");

    // The spare comparator code must behave as the mixed band on a falling step.
    a_spare_code: assert property (
        step_edge && decay_fraction_level == 2'h3 && level_of(pos_next) < level_of(pos_q)
        |=> mode1_q == DECAY_MIXED)
        else $error("spare fraction code not read as mixed");
endmodule // stepper_output_decay_control

/* bench/winding_model.sv */
// Purpose: Winding and comparator model standing beside the two bridges.
// Assumes: a bridge drives its winding while its gates show the drive pattern of its polarity.
// Notes: Trip comes after TRIP_CYC drive cycles; fraction and off-time count from decay start.
`timescale 1ns/1ps
module winding_model #(
    parameter int TRIP_CYC = 6,
    parameter int FRAC_CYC = 3,
    parameter int OFF_CYC = 7
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] gates,
    input wire logic [1:0] neg,
    output logic [1:0] trip,
    output logic [1:0] frac,
    output logic [1:0] expired
);
    logic [1:0] drv;
    logic [1:0] drv_q;
    logic [15:0] cnt_q [2];
    // Classify each bridge and raise the comparators from the phase time.
    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            drv[i] = gates[4*i+:4] == (neg[i] ? 4'h6 : 4'h9);
            trip[i] = drv[i] && drv_q[i] && cnt_q[i] >= 16'(TRIP_CYC);
            frac[i] = !drv[i] && !drv_q[i] && cnt_q[i] >= 16'(FRAC_CYC);
            expired[i] = !drv[i] && !drv_q[i] && cnt_q[i] >= 16'(OFF_CYC);
        end
    end
    // Restart the phase time when drive starts or stops.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            drv_q <= 2'h0;
            cnt_q <= '{16'h0000, 16'h0000};
        end
        else
        begin
            drv_q <= drv;
            for (int i = 0; i < 2; i++)
                cnt_q[i] <= (drv[i] != drv_q[i]) ? 16'h0000 : cnt_q[i] + 16'h0001;
        end
    end
endmodule // winding_model

/* bench/stepper_output_decay_control_bench.sv */
// Purpose: Self-checking bench for the stepper output and decay control.
// Assumes: zero-wait APB slave; the winding model closes the current loop.
// Notes: Wake time is shortened to 20 cycles.
`timescale 1ns/1ps
module stepper_output_decay_control_bench import stepper_pkg::*;;
    localparam int WAKE = 20;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [1:0] dfl = 2'h0;
    logic lockout = 1'b0;
    logic gate_low = 1'b0;
    logic [7:0] temp = 8'h19;
    logic [1:0] zc = 2'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, home, cp_on, reg_on, neg1, neg2;
    logic [1:0] trip, frac, expd;
    logic [3:0] g1, g2;
    logic [9:0] lv1, lv2;
    int mismatches = 0;
    int samples_checked = 0;
    // Clock at 125 MHz.
    initial
        forever #4 pclk = ~pclk;
    stepper_output_decay_control #(.WAKE_CYCLES_P(WAKE)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .decay_fraction_level(dfl), .supply_lockout(lockout), .gate_supply_rail_low(gate_low),
        .junction_temp_c(temp), .current_trip(trip), .off_timer_node_at_fraction(frac), .off_timer_expired(expd),
        .zero_current(zc), .bridge1_gate(g1), .bridge2_gate(g2), .phase1_level(lv1), .phase1_neg(neg1),
        .phase2_level(lv2), .phase2_neg(neg2), .home(home), .charge_pump_on(cp_on), .regulator_on(reg_on));
    winding_model u_wind (.pclk(pclk), .presetn(presetn), .gates({g2, g1}), .neg({neg2, neg1}),
        .trip(trip), .frac(frac), .expired(expd));
    // Compare one value and count it.
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One APB transfer; data and error are taken at the pready edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk); // Idle cycle before any next setup.
    endtask
    // Write the control word.
    task automatic wr(input logic [31:0] d);
        apb(1'b1, CTRL_OFS, d);
    endtask
    // Wait a bounded time for a bridge 1 gate pattern.
    task automatic wait_g1(input logic [3:0] e);
        for (int n = 0; n < 40 && g1 !== e; n++) @(posedge pclk);
        chk("bridge1_gate", 32'(g1), 32'(e));
    endtask
    // Reset state, control reset value and an unmapped access.
    task automatic t_reset();
        chk("home", 32'(home), 32'h1);
        chk("phase1_level", 32'(lv1), 32'h2C3);
        chk("gate", 32'(g1), 32'h0);
        apb(1'b0, CTRL_OFS, 32'h0);
        chk("ctrl", rd, 32'h17);
        apb(1'b0, 8'h40, 32'h0);
        chk("slverr", 32'(er), 32'h1);
        chk("unmapped", rd, 32'h0);
    endtask
    // One sixteenth step from Home per decay code, outputs disabled.
    task automatic t_step();
        for (int c = 0; c < 4; c++)
        begin
            dfl <= 2'(c);
            wr(32'h03);
            wr(32'h83);
            repeat (3) @(posedge pclk);
            chk("home", 32'(home), 32'h1);
            wr(32'h77);
            wr(32'hF7);
            repeat (3) @(posedge pclk);
            chk("home", 32'(home), 32'h0);
            chk("phase1_level", 32'(lv1), 32'h27A);
            chk("phase2_level", 32'(lv2), 32'h305);
            apb(1'b0, STATUS_OFS, 32'h0);
            chk("decay", 32'(rd[11:8]), 32'(c == 3 ? 1 : c));
            chk("position", 32'(rd[21:16]), 32'h9);
            apb(1'b0, LEVEL_OFS, 32'h0);
            chk("level", rd, 32'h0305_027A);
        end
    endtask
    // Mixed decay sequence, rectification modes and enable.
    task automatic t_decay();
        wr(32'h03);
        wr(32'h06);
        wait_g1(4'h9);
        wait_g1(4'h6);
        wait_g1(4'hA);
        wait_g1(4'h9);
        wr(32'h0E);
        wait_g1(4'h8);
        wr(32'h06);
        zc <= 2'h3;
        wait_g1(4'h9);
        wait_g1(4'h8);
        zc <= 2'h0;
        wr(32'h07);
        repeat (4) @(posedge pclk);
        chk("gate", 32'(g1), 32'h0);
    endtask
    // Gate rail fault, thermal hysteresis and supply lockout.
    task automatic t_fault();
        wr(32'h06);
        gate_low <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("gate", 32'(g1), 32'h0);
        gate_low <= 1'b0;
        wait_g1(4'h9);
        temp <= 8'hA5;
        repeat (4) @(posedge pclk);
        chk("gate", 32'(g1), 32'h0);
        temp <= 8'h97;
        repeat (4) @(posedge pclk);
        chk("gate", 32'(g1), 32'h0);
        temp <= 8'h96;
        wait_g1(4'h9);
        wr(32'h76);
        wr(32'hF6);
        lockout <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("home", 32'(home), 32'h1);
        chk("gate", 32'(g1), 32'h0);
        lockout <= 1'b0;
    endtask
    // Sleep entry, a step while asleep, and wake to Home.
    task automatic t_sleep();
        wr(32'h74);
        wr(32'hF4);
        repeat (4) @(posedge pclk);
        chk("pump", 32'({cp_on, reg_on, g1}), 32'h0);
        chk("home", 32'(home), 32'h0);
        wr(32'h76);
        repeat (3) @(posedge pclk);
        chk("home", 32'(home), 32'h1);
        repeat (WAKE) @(posedge pclk);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk("wake", 32'(rd[ST_WAKE_BIT]), 32'h1);
    endtask
    // Report the counts and end the run.
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Main sequence.
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (WAKE) @(posedge pclk);
        t_reset();
        t_step();
        t_decay();
        t_fault();
        t_sleep();
        tally_and_finish();
    end
    // Watchdog against a hang.
    initial
    begin
        repeat (5000) @(posedge pclk);
        mismatches++;
        tally_and_finish();
    end
endmodule // stepper_output_decay_control_bench
